/* common/smfar_pkg.sv */
// Constants shared by the aliased SIMD and float register file.
`default_nettype none
package smfar_pkg;

    // Register file geometry.
    localparam int unsigned NUM_REGS   = 8;
    localparam int unsigned FLOAT_W    = 80;
    localparam int unsigned SIMD_W     = 64;
    localparam int unsigned TAG_W      = 2;
    localparam int unsigned WORD16_W   = 16;

    // Operation codes issued by the execution pipeline.
    localparam logic [2:0] OP_SIMD_READ     = 3'h0;
    localparam logic [2:0] OP_SIMD_WRITE    = 3'h1;
    localparam logic [2:0] OP_EMPTY_SIMD    = 3'h2;
    localparam logic [2:0] OP_FLOAT_READ    = 3'h3;
    localparam logic [2:0] OP_FLOAT_WRITE   = 3'h4;
    localparam logic [2:0] OP_FLOAT_FREE    = 3'h5;
    localparam logic [2:0] OP_STATE_SAVE    = 3'h6;
    localparam logic [2:0] OP_STATE_RESTORE = 3'h7;

    // Tag encodings and whole-word tag values.
    localparam logic [1:0]  TAG_NONZERO   = 2'h0;
    localparam logic [1:0]  TAG_ZERO      = 2'h1;
    localparam logic [1:0]  TAG_SPECIAL   = 2'h2;
    localparam logic [1:0]  TAG_EMPTY     = 2'h3;
    localparam logic [15:0] TAGS_ALL_VALID = 16'h0000;
    localparam logic [15:0] TAGS_ALL_EMPTY = 16'hffff;
    localparam logic [15:0] TAG_FIELD_ONES = 16'h0003;

    // Float value fields.
    localparam int unsigned EXP_HI  = 78;
    localparam int unsigned EXP_LO  = 64;
    localparam int unsigned INT_BIT = 63;
    localparam logic [14:0] EXP_MAX  = 15'h7fff;
    localparam logic [14:0] EXP_NONE = 15'h0000;
    localparam logic [15:0] UPPER_ONES = 16'hffff;

    // Float status word: stack_top_field and the bits SIMD ops keep.
    localparam int unsigned TOP_LO = 11;
    localparam int unsigned TOP_HI = 13;
    localparam logic [2:0]  TOP_CLEAR        = 3'h0;
    localparam logic [15:0] STATUS_KEEP_MASK = 16'hc7ff;

    // machine_control_register bit positions.
    localparam int unsigned MCR_MON_BIT = 1;
    localparam int unsigned MCR_EMU_BIT = 2;
    localparam int unsigned MCR_TS_BIT  = 3;
    localparam logic [3:0]  MCR_WMASK   = 4'he;

    // APB byte offsets.
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_MCR       = 12'h000;
    localparam logic [11:0] OFS_STATUS    = 12'h004;
    localparam logic [11:0] OFS_TAG       = 12'h008;
    localparam logic [11:0] OFS_CWORD     = 12'h00c;
    localparam logic [11:0] OFS_SAVED_TAG = 12'h010;

    // Reset values.
    localparam logic [3:0]  MCR_RST    = 4'h0;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] TAG_RST    = 16'hffff;
    localparam logic [15:0] CWORD_RST  = 16'h0000;

endpackage : smfar_pkg
`default_nettype wire

/* logic/smfar_tag_class.sv */
// Classifies one float data register into its stored tag code.
`timescale 1ns/100ps
`default_nettype none
module smfar_tag_class
    import smfar_pkg::*;
(
    // Register value and its empty marking
    input  wire logic [79:0] value,
    input  wire logic        empty,
    // Derived tag
    output logic      [1:0]  tag
);

    logic [14:0] exponent;

    assign exponent = value[EXP_HI:EXP_LO];

    // Denormals and unnormals count as special, as do infinities and NaNs.
    always_comb begin
        if (empty) begin
            tag = TAG_EMPTY;
        end else if (exponent == EXP_NONE && value[INT_BIT:0] == 64'h0) begin
            tag = TAG_ZERO;
        end else if (exponent == EXP_MAX || exponent == EXP_NONE || !value[INT_BIT]) begin
            tag = TAG_SPECIAL;
        end else begin
            tag = TAG_NONZERO;
        end
    end

endmodule : smfar_tag_class
`default_nettype wire

/* logic/smfar_fault_gate.sv */
// Decides whether a SIMD operation runs or faults from the control flags.
`timescale 1ns/100ps
`default_nettype none
module smfar_fault_gate (
    // Issue and flags
    input  wire logic issue,
    input  wire logic emulate_flag,
    input  wire logic task_switched_flag,
    // Verdict
    output logic      exec_ok,
    output logic      invalid_opcode_fault,
    output logic      device_unavailable_fault
);

    // Emulation wins over task switching; the monitor flag plays no part.
    assign invalid_opcode_fault     = issue & emulate_flag;
    assign device_unavailable_fault = issue & ~emulate_flag & task_switched_flag;
    assign exec_ok                  = issue & ~emulate_flag & ~task_switched_flag;

endmodule : smfar_fault_gate
`default_nettype wire

/* logic/smfar_regfile.sv */
// Aliased SIMD and float register file with tag, stack-top and fault logic.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module smfar_regfile
    import smfar_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Operation request from the pipeline
    input  wire logic        op_valid,
    input  wire logic [2:0]  op_code,
    input  wire logic [2:0]  op_reg,
    input  wire logic [79:0] op_wdata,
    input  wire logic [15:0] op_tag_in,
    // Operation answer
    output logic             op_done,
    output logic      [79:0] op_rdata,
    output logic      [15:0] stored_tag_image,
    output logic             invalid_opcode_fault,
    output logic             device_unavailable_fault
);

    typedef struct packed {
        logic [7:0][79:0] fdata;
        logic [15:0]      tag;
        logic [15:0]      status;
        logic [15:0]      cword;
        logic [3:0]       mcr;
        logic [15:0]      saved_tag;
        logic [79:0]      rdata;
        logic             done;
        logic             ud;
        logic             nm;
        logic             ack;
        logic             err;
        logic [31:0]      prdata;
    } smfar_state_t;

    smfar_state_t st;
    smfar_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Operation decode and fault gating

    logic        is_simd;
    logic        exec_ok;
    logic        ud_c;
    logic        nm_c;
    logic        simd_issue;
    logic [15:0] class_tag;
    logic [7:0]  empty_sel;
    logic [63:0] sel_low;
    logic [63:0] wdata_low;
    logic [15:0] field_mask;

    assign is_simd    = (op_code == OP_SIMD_READ) || (op_code == OP_SIMD_WRITE)
                     || (op_code == OP_EMPTY_SIMD);
    assign simd_issue = op_valid & is_simd;
    assign sel_low    = st.fdata[op_reg][63:0];
    assign wdata_low  = op_wdata[63:0];
    assign field_mask = TAG_FIELD_ONES << {op_reg, 1'b0};

    smfar_fault_gate u_gate (
        .issue                    (simd_issue),
        .emulate_flag             (st.mcr[MCR_EMU_BIT]),
        .task_switched_flag       (st.mcr[MCR_TS_BIT]),
        .exec_ok                  (exec_ok),
        .invalid_opcode_fault     (ud_c),
        .device_unavailable_fault (nm_c)
    );

    // Restore judges emptiness from the memory image, save from the live tags.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_class
            assign empty_sel[gi] = (op_code == OP_STATE_RESTORE)
                ? (op_tag_in[2*gi +: 2] == TAG_EMPTY)
                : (st.tag[2*gi +: 2] == TAG_EMPTY);
            smfar_tag_class u_class (
                .value (st.fdata[gi]),
                .empty (empty_sel[gi]),
                .tag   (class_tag[2*gi +: 2])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    logic        apb_access;
    logic        apb_wr;
    logic        addr_hit;
    logic [31:0] rd_word;

    assign apb_access = psel & penable & ~st.ack;
    assign apb_wr     = st.ack & psel & penable & pwrite & ~st.err;

    always_comb begin
        rd_word  = 32'h0;
        addr_hit = 1'b1;
        case (paddr)
            OFS_MCR:       rd_word = {28'h0, st.mcr};
            OFS_STATUS:    rd_word = {16'h0, st.status};
            OFS_TAG:       rd_word = {16'h0, st.tag};
            OFS_CWORD:     rd_word = {16'h0, st.cword};
            OFS_SAVED_TAG: rd_word = {16'h0, st.saved_tag};
            default:       addr_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        next_st.ud   = 1'b0;
        next_st.nm   = 1'b0;

        // One wait state lets read data come from a flip-flop.
        next_st.ack = apb_access;
        if (apb_access) begin
            next_st.prdata = rd_word;
            next_st.err    = ~addr_hit;
        end
        if (apb_wr) begin
            case (paddr)
                OFS_MCR:    next_st.mcr = pwdata[3:0] & MCR_WMASK;
                OFS_STATUS: next_st.status = pwdata[15:0];
                OFS_TAG:    next_st.tag = pwdata[15:0];
                OFS_CWORD:  next_st.cword = pwdata[15:0];
                default:    ;
            endcase
        end

        // Operations are applied after bus writes, so they win on a clash.
        if (simd_issue && !exec_ok) begin
            next_st.ud = ud_c;
            next_st.nm = nm_c;
        end else if (op_valid) begin
            next_st.done = 1'b1;
            if (is_simd) begin
                next_st.status[TOP_HI:TOP_LO] = TOP_CLEAR;
            end
            case (op_code)
                OP_SIMD_READ: begin
                    // Index is the physical register number, never stack-relative.
                    next_st.rdata = {16'h0, sel_low};
                    next_st.tag   = TAGS_ALL_VALID;
                end
                OP_SIMD_WRITE: begin
                    next_st.fdata[op_reg] = {UPPER_ONES, wdata_low};
                    next_st.tag           = TAGS_ALL_VALID;
                end
                OP_EMPTY_SIMD: begin
                    next_st.tag = TAGS_ALL_EMPTY;
                end
                OP_FLOAT_READ: begin
                    next_st.rdata = st.fdata[op_reg];
                end
                OP_FLOAT_WRITE: begin
                    next_st.fdata[op_reg] = op_wdata;
                    next_st.tag = (st.tag & ~field_mask);
                end
                OP_FLOAT_FREE: begin
                    next_st.tag = st.tag | field_mask;
                end
                OP_STATE_SAVE: begin
                    next_st.saved_tag = class_tag;
                    next_st.tag       = TAGS_ALL_EMPTY;
                end
                OP_STATE_RESTORE: begin
                    next_st.tag = class_tag;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st        <= '0;
            st.tag    <= TAG_RST;
            st.status <= STATUS_RST;
            st.cword  <= CWORD_RST;
            st.mcr    <= MCR_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata                   = st.prdata;
    assign pready                   = st.ack;
    assign pslverr                  = st.ack & st.err;
    assign op_done                  = st.done;
    assign op_rdata                 = st.rdata;
    assign stored_tag_image         = st.saved_tag;
    assign invalid_opcode_fault     = st.ud;
    assign device_unavailable_fault = st.nm;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_emulate_ud: assert property (
        simd_issue && st.mcr[MCR_EMU_BIT]
        |=> invalid_opcode_fault && !device_unavailable_fault && !op_done)
        else $error("SIMD op with emulate flag did not raise invalid opcode");

    a_switched_nm: assert property (
        simd_issue && !st.mcr[MCR_EMU_BIT] && st.mcr[MCR_TS_BIT]
        |=> device_unavailable_fault && !invalid_opcode_fault && $stable(st.fdata))
        else $error("SIMD op with task switched did not fault cleanly");

    a_simd_runs: assert property (
        simd_issue && !st.mcr[MCR_EMU_BIT] && !st.mcr[MCR_TS_BIT]
        |=> op_done && !invalid_opcode_fault && !device_unavailable_fault)
        else $error("Permitted SIMD op did not execute");

    a_fixed_map: assert property (
        exec_ok && op_code == OP_SIMD_READ
        |=> op_rdata[63:0] == $past(sel_low))
        else $error("SIMD read did not return physical register low bits");

    a_alias_low: assert property (
        exec_ok && op_code == OP_SIMD_WRITE
        |=> st.fdata[$past(op_reg)][63:0] == $past(wdata_low))
        else $error("SIMD write not visible in float register low bits");

    a_upper_ones: assert property (
        exec_ok && op_code == OP_SIMD_WRITE
        |=> st.fdata[$past(op_reg)][79:64] == UPPER_ONES)
        else $error("SIMD write did not set upper float bits to ones");

    a_tags_valid: assert property (
        exec_ok && op_code != OP_EMPTY_SIMD |=> st.tag == TAGS_ALL_VALID)
        else $error("SIMD op did not mark all tags valid");

    a_tags_empty: assert property (
        exec_ok && op_code == OP_EMPTY_SIMD
        |=> st.tag == TAGS_ALL_EMPTY && $stable(st.fdata))
        else $error("Empty-state op did not empty tags or touched data");

    a_top_cleared: assert property (
        exec_ok |=> st.status[TOP_HI:TOP_LO] == TOP_CLEAR)
        else $error("SIMD op left stack top nonzero");

    a_status_kept: assert property (
        exec_ok && !apb_wr
        |=> (st.status & STATUS_KEEP_MASK) == ($past(st.status) & STATUS_KEEP_MASK)
            && $stable(st.cword))
        else $error("SIMD op disturbed status or control word");

    a_save_image: assert property (
        op_valid && op_code == OP_STATE_SAVE |=> stored_tag_image == $past(class_tag))
        else $error("Stored tag image does not match classification");

    a_save_empties: assert property (
        op_valid && op_code == OP_STATE_SAVE ##1 !op_valid && !apb_wr
        |=> st.tag == TAGS_ALL_EMPTY)
        else $error("Live tags not empty after save");

    a_restore_tags: assert property (
        op_valid && op_code == OP_STATE_RESTORE
        |=> st.tag == $past(class_tag) && $stable(st.saved_tag))
        else $error("Restore produced wrong tags or altered image");

    a_float_tag: assert property (
        op_valid && op_code == OP_FLOAT_WRITE && !apb_wr
        |=> (st.tag & $past(field_mask)) == TAGS_ALL_VALID
            && (st.tag | $past(field_mask)) == ($past(st.tag) | $past(field_mask)))
        else $error("Float write changed the wrong tags");

    a_ud_no_effect: assert property (
        simd_issue && st.mcr[MCR_EMU_BIT] && !apb_wr
        |=> $stable(st.tag) && $stable(st.status) && $stable(st.fdata))
        else $error("SIMD op with emulate flag changed register state");

    a_nm_no_effect: assert property (
        simd_issue && !st.mcr[MCR_EMU_BIT] && st.mcr[MCR_TS_BIT] && !apb_wr
        |=> $stable(st.tag) && $stable(st.status))
        else $error("SIMD op with task switched changed tags or status");

    a_float_no_fault: assert property (
        op_valid && !is_simd
        |=> op_done && !invalid_opcode_fault && !device_unavailable_fault)
        else $error("Float or save op faulted or did not complete");

    a_read_keeps_data: assert property (
        exec_ok && op_code == OP_SIMD_READ
        |=> $stable(st.fdata))
        else $error("SIMD read altered float register contents");

    a_tags_no_effect: assert property (
        exec_ok && op_code == OP_SIMD_READ && st.tag == TAGS_ALL_EMPTY
        |=> op_done && op_rdata == {16'h0, $past(st.fdata[op_reg][63:0])})
        else $error("Empty tags changed the result of a SIMD read");

    a_float_alias: assert property (
        op_valid && op_code == OP_FLOAT_WRITE
        |=> st.fdata[$past(op_reg)] == $past(op_wdata))
        else $error("Float write not stored in full");

    a_float_free: assert property (
        op_valid && op_code == OP_FLOAT_FREE && !apb_wr
        |=> (st.tag & $past(field_mask)) == $past(field_mask)
            && (st.tag & ~$past(field_mask)) == ($past(st.tag) & ~$past(field_mask)))
        else $error("Float free changed the wrong tags");

    a_save_data: assert property (
        op_valid && (op_code == OP_STATE_RESTORE || op_code == OP_STATE_SAVE)
        |=> $stable(st.fdata))
        else $error("Save or restore altered float register contents");

endmodule : smfar_regfile
`default_nettype wire

/* tb/smfar_pipe_model.sv */
// Behavioural model of the execution pipeline that issues register operations.
`timescale 1ns/100ps
`default_nettype none
module smfar_pipe_model
    import smfar_pkg::*;
(
    // Clock
    input  wire logic        pclk,
    // Operation request
    output logic             op_valid,
    output logic      [2:0]  op_code,
    output logic      [2:0]  op_reg,
    output logic      [79:0] op_wdata,
    output logic      [15:0] op_tag_in
);
    initial begin
        op_valid  = 1'b0;
        op_code   = 3'h0;
        op_reg    = 3'h0;
        op_wdata  = 80'h0;
        op_tag_in = 16'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One operation lasts one cycle. Once it is taken op_valid drops and the
    // operands are inverted, so the block cannot lean on a stale operand.
    task automatic issue(input logic [2:0] c, input logic [2:0] r,
                         input logic [79:0] d, input logic [15:0] ti);
        @(posedge pclk);
        op_valid  <= 1'b1;
        op_code   <= c;
        op_reg    <= r;
        op_wdata  <= d;
        op_tag_in <= ti;
        @(posedge pclk);
        op_valid  <= 1'b0;
        op_reg    <= ~r;
        op_wdata  <= ~d;
        op_tag_in <= ~ti;
    endtask : issue
endmodule : smfar_pipe_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench for the aliased SIMD and float register file.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import smfar_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        op_valid, op_done, invalid_opcode_fault, device_unavailable_fault;
    logic [2:0]  op_code, op_reg;
    logic [79:0] op_wdata, op_rdata;
    logic [15:0] op_tag_in, stored_tag_image;
    logic [79:0] m_reg [8];
    logic [15:0] m_tag, m_status, m_cword, m_saved;
    logic [3:0]  m_mcr;
    int          n_fail, num_checks;
    integer      seed;

    smfar_regfile dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code),
        .op_reg(op_reg), .op_wdata(op_wdata), .op_tag_in(op_tag_in), .op_done(op_done),
        .op_rdata(op_rdata), .stored_tag_image(stored_tag_image),
        .invalid_opcode_fault(invalid_opcode_fault),
        .device_unavailable_fault(device_unavailable_fault));
    smfar_pipe_model pipe (.pclk(pclk), .op_valid(op_valid), .op_code(op_code),
        .op_reg(op_reg), .op_wdata(op_wdata), .op_tag_in(op_tag_in));

    always #20 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (n_fail == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // The master waits for pready without assuming the wait-state count.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~wd;
        if (n >= 50) begin
            n_fail++;
            end_sim();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic xe);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(rd, exp);
        chk(e, xe);
    endtask : rdc

    task automatic check_state;
        rdc(OFS_STATUS, {16'h0, m_status}, 1'b0);
        rdc(OFS_TAG, {16'h0, m_tag}, 1'b0);
        rdc(OFS_CWORD, {16'h0, m_cword}, 1'b0);
    endtask : check_state

    function automatic logic [1:0] cls(input logic [79:0] v, input logic [1:0] tg);
        if (tg == 2'h3) return 2'h3;
        if (v[78:64] == 15'h0 && v[63:0] == 64'h0) return 2'h1;
        if (v[78:64] == 15'h7fff || v[78:64] == 15'h0 || !v[63]) return 2'h2;
        return 2'h0;
    endfunction : cls

    function automatic logic [79:0] rnd80();
        logic [95:0] x;
        x = {$random(seed), $random(seed), $random(seed)};
        return x[79:0];
    endfunction : rnd80

    ////////////////////////////////////////////////////////////////////////////
    // Issues one operation, then updates the model and compares every result.
    task automatic op(input logic [2:0] c, input logic [2:0] r, input logic [79:0] d,
                      input logic [15:0] ti);
        logic ud, nm, ok;
        logic [15:0] t;
        ud = (c <= OP_EMPTY_SIMD) && m_mcr[MCR_EMU_BIT];
        nm = (c <= OP_EMPTY_SIMD) && !m_mcr[MCR_EMU_BIT] && m_mcr[MCR_TS_BIT];
        ok = !ud && !nm;
        pipe.issue(c, r, d, ti);
        #1;
        chk(invalid_opcode_fault, ud);
        chk(device_unavailable_fault, nm);
        chk(op_done, ok);
        if (ok && c <= OP_EMPTY_SIMD) m_status[13:11] = 3'h0;
        for (int k = 0; k < 8; k++) begin
            t[2*k +: 2] = (c == OP_STATE_SAVE) ? cls(m_reg[k], m_tag[2*k +: 2]) :
                (ti[2*k +: 2] == 2'h3) ? 2'h3 : cls(m_reg[k], 2'h0);
        end
        if (ok) begin
            case (c)
                OP_SIMD_READ: begin
                    m_tag = 16'h0;
                    chk(op_rdata, {16'h0, m_reg[r][63:0]});
                end
                OP_SIMD_WRITE: begin
                    m_tag = 16'h0;
                    m_reg[r] = {16'hffff, d[63:0]};
                end
                OP_EMPTY_SIMD: m_tag = 16'hffff;
                OP_FLOAT_READ: chk(op_rdata, m_reg[r]);
                OP_FLOAT_WRITE: begin
                    m_reg[r] = d;
                    m_tag[2*r +: 2] = 2'h0;
                end
                OP_FLOAT_FREE: m_tag[2*r +: 2] = 2'h3;
                OP_STATE_SAVE: begin
                    m_saved = t;
                    m_tag = 16'hffff;
                    chk(stored_tag_image, m_saved);
                end
                default: begin
                    m_tag = t;
                    chk(stored_tag_image, m_saved);
                end
            endcase
        end
    endtask : op

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h4361;
        foreach (m_reg[k]) m_reg[k] = 80'h0;
        {m_tag, m_status, m_cword, m_saved, m_mcr} = {16'hffff, 52'h0};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFS_MCR, 32'h0, 1'b0);
        rdc(OFS_SAVED_TAG, 32'h0, 1'b0);
        check_state;
        wr(12'h020, 32'hffffffff);
        wr(OFS_SAVED_TAG, 32'h1234);
        rdc(12'h020, 32'h0, 1'b1);
        rdc(OFS_SAVED_TAG, 32'h0, 1'b0);
        m_cword = 16'($random(seed));
        wr(OFS_CWORD, {16'h0, m_cword});
        // Every emulate and task-switched flag combination, monitor flag held set, against every SIMD operation kind.
        for (int f = 0; f < 12; f++) begin
            m_mcr = {f[1], f[0], 2'h2};
            wr(OFS_MCR, {28'h0, m_mcr});
            rdc(OFS_MCR, {28'h0, m_mcr}, 1'b0);
            op(3'(f / 4), 3'($random(seed)), rnd80(), 16'h0);
            check_state;
        end
        m_mcr = 4'h2;
        wr(OFS_MCR, 32'h2);
        for (int i = 0; i < 8; i++) op(OP_FLOAT_READ, 3'(i), 80'h0, 16'h0);
        // SIMD writes under a non-zero stack top, then float reads back.
        for (int i = 0; i < 8; i++) begin
            m_status = 16'($random(seed)) | 16'h2800;
            wr(OFS_STATUS, {16'h0, m_status});
            op(OP_SIMD_WRITE, 3'(i), rnd80(), 16'h0);
            check_state;
        end
        for (int i = 0; i < 8; i++) op(OP_FLOAT_READ, 3'(i), 80'h0, 16'h0);
        for (int i = 0; i < 8; i++) begin
            op(OP_FLOAT_WRITE, 3'(i), rnd80(), 16'h0);
            m_tag = 16'($random(seed));
            wr(OFS_TAG, {16'h0, m_tag});
            op(OP_SIMD_READ, 3'(i), 80'h0, 16'h0);
            op(OP_FLOAT_READ, 3'(i), 80'h0, 16'h0);
        end
        check_state;
        op(OP_EMPTY_SIMD, 3'h0, 80'h0, 16'h0);
        check_state;
        op(OP_FLOAT_READ, 3'h3, 80'h0, 16'h0);
        op(OP_SIMD_READ, 3'h1, 80'h0, 16'h0);
        op(OP_FLOAT_FREE, 3'h5, 80'h0, 16'h0);
        op(OP_FLOAT_WRITE, 3'h6, rnd80(), 16'h0);
        check_state;
        // One register of every class, then save and restore.
        op(OP_FLOAT_WRITE, 3'h0, 80'h0, 16'h0);
        op(OP_FLOAT_WRITE, 3'h1, 80'h3fff_8000_0000_0000_0000, 16'h0);
        op(OP_FLOAT_WRITE, 3'h2, 80'h7fff_8000_0000_0000_0000, 16'h0);
        op(OP_FLOAT_WRITE, 3'h3, 80'h0000_0000_0000_0000_0001, 16'h0);
        op(OP_FLOAT_WRITE, 3'h4, 80'h4000_0000_0000_0000_0001, 16'h0);
        op(OP_FLOAT_WRITE, 3'h5, 80'h8000_0000_0000_0000_0000, 16'h0);
        op(OP_FLOAT_FREE, 3'h7, 80'h0, 16'h0);
        op(OP_STATE_SAVE, 3'h0, 80'h0, 16'h0);
        check_state;
        rdc(OFS_SAVED_TAG, {16'h0, m_saved}, 1'b0);
        for (int i = 0; i < 4; i++) begin
            op(OP_STATE_RESTORE, 3'h0, 80'h0, 16'($random(seed)));
            check_state;
            op(OP_STATE_SAVE, 3'h0, 80'h0, 16'h0);
        end
        // A second reset in mid-run must bring back every reset value.
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (m_reg[k]) m_reg[k] = 80'h0;
        {m_tag, m_status, m_cword, m_saved, m_mcr} = {16'hffff, 52'h0};
        chk(stored_tag_image, 16'h0);
        rdc(OFS_MCR, 32'h0, 1'b0);
        check_state;
        op(OP_SIMD_READ, 3'h4, 80'h0, 16'h0);
        check_state;
        end_sim();
    end

    initial begin
        #800000;
        n_fail++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
